// ---- rtl/ebt_bus_timing.v ----
// external multiplexed bus cycle sequencer with programmable timing
//
// Functional notes
// - latch strobe first, write strobes only afterwards
// - 8-bit bus byte write uses low strobe only
// - 16-bit byte write: even low, odd high
// - 16-bit word write asserts both strobes together
// - 8-bit word write: low byte even, high odd
// - split word write issues one latch strobe only
// - second write length codes give 2 to 5
// - latched write total length codes give 2 to 5
// - second read length codes give 1 to 4
// - latched read total length codes give 2 to 5
// - latched cycles counted from latch strobe assertion
// - unlatched cycles counted from strobe assertion
// - cycle ends at phase count end or hold end; the second write phase holds data after its strobe when the phase is longer than the strobe
// - one idle clock after every bus cycle
// - write strobe one or two clocks wide
`timescale 1ns/1ps
`include "ebt_defs.vh"

module ebt_bus_timing (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // cpu request side
  input  wire        req_valid,
  input  wire        req_write,
  input  wire        req_word,
  input  wire [23:0] req_addr,
  input  wire [15:0] req_wdata,
  output reg         req_ready,
  output reg         rsp_valid,
  output reg  [15:0] rsp_rdata,
  // external bus pins
  output reg         ale,
  output reg         write_strobe_low_n,
  output reg         write_strobe_high_n,
  output reg         read_strobe_n,
  output reg  [23:0] bus_addr,
  output reg  [15:0] bus_dout,
  output reg         bus_doe,
  input  wire [15:0] bus_din
);

  localparam ST_IDLE   = 3'd0;
  localparam ST_FIRST  = 3'd1;
  localparam ST_HOLD   = 3'd2;
  localparam ST_REST   = 3'd3;
  localparam ST_SECOND = 3'd4;

  wire [7:0] high_reg;
  wire [7:0] low_reg;
  wire [7:0] cfg_reg;
  wire [7:0] status_word;

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [2:0]  cnt_reg;
  reg  [2:0]  cnt_next;
  reg  [2:0]  len_reg;
  reg  [2:0]  len_next;
  reg  [2:0]  sec_len_reg;
  reg  [2:0]  sec_len_next;
  reg  [2:0]  wpw_reg;
  reg  [2:0]  wpw_next;
  reg         hold_reg;
  reg         hold_next;
  reg         write_reg;
  reg         write_next;
  reg         split_reg;
  reg         split_next;
  reg  [1:0]  lane_reg;
  reg  [1:0]  lane_next;
  reg  [23:0] addr_reg;
  reg  [23:0] addr_next;
  reg  [15:0] data_reg;
  reg  [15:0] data_next;
  reg  [7:0]  hi_byte_reg;
  reg  [7:0]  hi_byte_next;
  reg  [15:0] rdata_reg;
  reg  [15:0] rdata_next;
  reg         done_next;

  // pin values derived from the next state
  reg         ale_next;
  reg         wr_low_next;
  reg         wr_high_next;
  reg         rd_next;
  reg         doe_next;
  reg  [2:0]  wr_start;

  wire        bus16;
  wire        phase_end;

  // length code to clock count
  function [2:0] dec_len;
    input [1:0] code;
    input [2:0] base;
    begin
      dec_len = {1'b0, code} + base;
    end
  endfunction

  // write strobe is placed at the tail of the latched cycle
  function [2:0] strobe_start;
    input [2:0] len;
    input [2:0] width;
    begin
      if (len > (width + `EBT_CNT_ONE))
        strobe_start = len - width;
      else
        strobe_start = `EBT_CNT_ONE;
    end
  endfunction

  assign bus16       = cfg_reg[`EBT_BUS16_BIT];
  assign phase_end   = (cnt_reg == (len_reg - `EBT_CNT_ONE));
  assign status_word = {4'h0, state_reg, ~req_ready};

  ebt_regs u_regs (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .status_in (status_word),
    .high_reg  (high_reg),
    .low_reg   (low_reg),
    .cfg_reg   (cfg_reg)
  );

  // sequencer
  always @*
  begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    len_next     = len_reg;
    sec_len_next = sec_len_reg;
    wpw_next     = wpw_reg;
    hold_next    = hold_reg;
    write_next   = write_reg;
    split_next   = split_reg;
    lane_next    = lane_reg;
    addr_next    = addr_reg;
    data_next    = data_reg;
    hi_byte_next = hi_byte_reg;
    rdata_next   = rdata_reg;
    done_next    = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          // timing is snapshotted here so a later register write cannot bend this cycle
          state_next = ST_FIRST;
          cnt_next   = `EBT_CNT_ZERO;
          write_next = req_write;
          hold_next  = low_reg[`EBT_HOLD_BIT];
          wpw_next   = low_reg[`EBT_WPW_BIT] ? `EBT_WPW_WIDE : `EBT_WPW_NARROW;
          split_next = req_word & ~bus16;
          rdata_next = 16'h0000;
          if (req_write)
          begin
            len_next     = dec_len(high_reg[`EBT_LW_MSB:`EBT_LW_LSB], `EBT_LAT_BASE);
            sec_len_next = dec_len(high_reg[`EBT_SW_MSB:`EBT_SW_LSB], `EBT_SWR_BASE);
          end
          else
          begin
            len_next     = dec_len(high_reg[`EBT_LR_MSB:`EBT_LR_LSB], `EBT_LAT_BASE);
            sec_len_next = dec_len(high_reg[`EBT_SR_MSB:`EBT_SR_LSB], `EBT_SRD_BASE);
          end
          hi_byte_next = req_wdata[15:8];
          if (req_word & bus16)
          begin
            lane_next = `EBT_LANE_BOTH;
            addr_next = req_addr;
            data_next = req_wdata;
          end
          else if (bus16)
          begin
            lane_next = req_addr[0] ? `EBT_LANE_HIGH : `EBT_LANE_LOW;
            addr_next = req_addr;
            data_next = {req_wdata[7:0], req_wdata[7:0]};
          end
          else
          begin
            lane_next = `EBT_LANE_LOW;
            addr_next = req_word ? {req_addr[23:1], 1'b0} : req_addr;
            data_next = {8'h00, req_wdata[7:0]};
          end
        end
      end
      ST_FIRST, ST_SECOND:
      begin
        if (phase_end)
        begin
          cnt_next = `EBT_CNT_ZERO;
          // cycle ends with the phase count, or after one more clock of data hold
          state_next = (write_reg & hold_reg) ? ST_HOLD : ST_REST;
          if (!write_reg)
          begin
            if (state_reg == ST_SECOND)
              rdata_next = {bus_din[7:0], rdata_reg[7:0]};
            else if (bus16)
              rdata_next = bus_din;
            else
              rdata_next = {8'h00, bus_din[7:0]};
          end
        end
        else
          cnt_next = cnt_reg + `EBT_CNT_ONE;
      end
      ST_HOLD:
        state_next = ST_REST;
      ST_REST:
      begin
        // rest clock: no strobe, no drive, before any new cycle
        if (split_reg)
        begin
          // second byte keeps the latched upper address, no new latch pulse
          state_next = ST_SECOND;
          cnt_next   = `EBT_CNT_ZERO;
          len_next   = sec_len_reg;
          split_next = 1'b0;
          addr_next  = {addr_reg[23:1], 1'b1};
          data_next  = {8'h00, hi_byte_reg};
        end
        else
        begin
          state_next = ST_IDLE;
          done_next  = 1'b1;
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // pin decode from the state about to be entered, so pins are plain flops
  always @*
  begin
    ale_next     = 1'b0;
    wr_low_next  = 1'b0;
    wr_high_next = 1'b0;
    rd_next      = 1'b0;
    doe_next     = 1'b0;
    wr_start     = strobe_start(len_next, wpw_next);
    case (state_next)
      ST_FIRST:
      begin
        ale_next = (cnt_next == `EBT_CNT_ZERO);
        doe_next = write_next & (cnt_next != `EBT_CNT_ZERO);
        if (write_next & (cnt_next >= wr_start))
        begin
          wr_low_next  = lane_next[0];
          wr_high_next = lane_next[1];
        end
        rd_next = ~write_next & (cnt_next >= `EBT_CNT_ONE);
      end
      ST_SECOND:
      begin
        doe_next = write_next;
        // strobe from the phase start; any rest of the phase holds data
        if (write_next & (cnt_next < wpw_next))
          wr_low_next = 1'b1;
        rd_next = ~write_next;
      end
      ST_HOLD:
        doe_next = 1'b1;
      default:
      begin
        ale_next = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg   <= ST_IDLE;
      cnt_reg     <= `EBT_CNT_ZERO;
      len_reg     <= `EBT_LAT_BASE;
      sec_len_reg <= `EBT_SWR_BASE;
      wpw_reg     <= `EBT_WPW_NARROW;
      hold_reg    <= 1'b0;
      write_reg   <= 1'b0;
      split_reg   <= 1'b0;
      lane_reg    <= `EBT_LANE_NONE;
      addr_reg    <= 24'h00_0000;
      data_reg    <= 16'h0000;
      hi_byte_reg <= 8'h00;
      rdata_reg   <= 16'h0000;
    end
    else
    begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      len_reg     <= len_next;
      sec_len_reg <= sec_len_next;
      wpw_reg     <= wpw_next;
      hold_reg    <= hold_next;
      write_reg   <= write_next;
      split_reg   <= split_next;
      lane_reg    <= lane_next;
      addr_reg    <= addr_next;
      data_reg    <= data_next;
      hi_byte_reg <= hi_byte_next;
      rdata_reg   <= rdata_next;
    end
  end

  // registered outputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_ready           <= 1'b0;
      rsp_valid           <= 1'b0;
      rsp_rdata           <= 16'h0000;
      ale                 <= 1'b0;
      write_strobe_low_n  <= 1'b1;
      write_strobe_high_n <= 1'b1;
      read_strobe_n       <= 1'b1;
      bus_addr            <= 24'h00_0000;
      bus_dout            <= 16'h0000;
      bus_doe             <= 1'b0;
    end
    else
    begin
      req_ready           <= (state_next == ST_IDLE);
      rsp_valid           <= done_next;
      rsp_rdata           <= done_next ? rdata_next : rsp_rdata;
      ale                 <= ale_next;
      write_strobe_low_n  <= ~wr_low_next;
      write_strobe_high_n <= ~wr_high_next;
      read_strobe_n       <= ~rd_next;
      bus_addr            <= addr_next;
      bus_dout            <= data_next;
      bus_doe             <= doe_next;
    end
  end

endmodule

// ---- rtl/ebt_defs.vh ----
// constants for the external bus write and cycle timing block
`ifndef EBT_DEFS_VH
`define EBT_DEFS_VH

// register byte offsets on the apb side
`define EBT_OFF_HIGH     12'h000
`define EBT_OFF_LOW      12'h004
`define EBT_OFF_CFG      12'h008
`define EBT_OFF_STAT     12'h00c

// reset values
`define EBT_HIGH_RST     8'hff
`define EBT_LOW_RST      8'h00
`define EBT_CFG_RST      8'h00

// bus_cycle_length_high fields
`define EBT_SW_MSB       7
`define EBT_SW_LSB       6
`define EBT_LW_MSB       5
`define EBT_LW_LSB       4
`define EBT_SR_MSB       3
`define EBT_SR_LSB       2
`define EBT_LR_MSB       1
`define EBT_LR_LSB       0

// bus_cycle_length_low fields
`define EBT_WPW_BIT      7
`define EBT_HOLD_BIT     6

// configuration register fields
`define EBT_BUS16_BIT    0

// length code offsets in clocks
`define EBT_LAT_BASE     3'd2
`define EBT_SWR_BASE     3'd2
`define EBT_SRD_BASE     3'd1

// write strobe widths in clocks
`define EBT_WPW_NARROW   3'd1
`define EBT_WPW_WIDE     3'd2

// phase counter landmarks
`define EBT_CNT_ZERO     3'd0
`define EBT_CNT_ONE      3'd1

// lane masks: bit 0 low byte, bit 1 high byte
`define EBT_LANE_LOW     2'b01
`define EBT_LANE_HIGH    2'b10
`define EBT_LANE_BOTH    2'b11
`define EBT_LANE_NONE    2'b00

`endif

// ---- rtl/ebt_regs.v ----
// apb register file for the external bus timing block
`timescale 1ns/1ps
`include "ebt_defs.vh"

module ebt_regs (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // block side
  input  wire [7:0]  status_in,
  output reg  [7:0]  high_reg,
  output reg  [7:0]  low_reg,
  output reg  [7:0]  cfg_reg
);

  wire setup_phase;
  wire access_done;
  reg  mapped;
  reg  [7:0] rd_mux;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;

  always @*
  begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    case (paddr)
      `EBT_OFF_HIGH: rd_mux = high_reg;
      `EBT_OFF_LOW:  rd_mux = low_reg;
      `EBT_OFF_CFG:  rd_mux = cfg_reg;
      `EBT_OFF_STAT: rd_mux = status_in;
      default:       mapped = 1'b0;
    endcase
  end

  // zero wait states: pready rises for the access phase only
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~mapped;
      prdata  <= (setup_phase & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  // status is read only; writes to it are dropped without error
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_reg <= `EBT_HIGH_RST;
      low_reg  <= `EBT_LOW_RST;
      cfg_reg  <= `EBT_CFG_RST;
    end
    else if (access_done & pwrite)
    begin
      if (paddr == `EBT_OFF_HIGH)
        high_reg <= pwdata[7:0];
      if (paddr == `EBT_OFF_LOW)
        low_reg <= pwdata[7:0];
      if (paddr == `EBT_OFF_CFG)
        cfg_reg <= pwdata[7:0];
    end
  end

endmodule

// ---- tb/ebt_bus_monitor.sv ----
// assertion checker for the external bus timing block
`timescale 1ns/1ps
module ebt_bus_monitor (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // request side
  input wire        rsp_valid,
  input wire        req_ready,
  // bus pins
  input wire        ale,
  input wire        write_strobe_low_n,
  input wire        write_strobe_high_n,
  input wire        read_strobe_n,
  input wire [23:0] bus_addr,
  input wire        bus_doe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence strobes_off_s;
    write_strobe_low_n && write_strobe_high_n && read_strobe_n;
  endsequence
  sequence quiet_s;
    write_strobe_low_n && write_strobe_high_n && read_strobe_n && !ale;
  endsequence
  sequence rest_s;
    quiet_s ##0 !bus_doe;
  endsequence
  ale_alone_a: assert property (ale |-> strobes_off_s ##0 !bus_doe)
    else $error("strobe or data drive during latch pulse");
  ale_single_a: assert property (ale |=> !ale until rsp_valid)
    else $error("second latch pulse within one operation");
  cycle_bound_a: assert property (ale |-> ##[3:20] rsp_valid)
    else $error("operation did not finish in time");
  read_rest_a: assert property ($rose(read_strobe_n) |-> rest_s)
    else $error("no idle clock after read strobe");
  write_rest_a: assert property ($fell(bus_doe) |-> rest_s)
    else $error("no idle clock after write data");
  read_excl_a: assert property (!read_strobe_n |-> write_strobe_low_n && write_strobe_high_n && !bus_doe)
    else $error("write activity during read strobe");
  strobe_data_a: assert property ((!write_strobe_low_n || !write_strobe_high_n) |-> bus_doe)
    else $error("write strobe without driven data");
  pulse_width_a: assert property ($fell(write_strobe_low_n) |-> ##[1:2] write_strobe_low_n)
    else $error("write strobe too wide");
  split_addr_a: assert property ($changed(bus_addr) && !ale |-> bus_addr == ($past(bus_addr) | 24'h1))
    else $error("address change without latch is not the odd byte");
  rsp_pulse_a: assert property (rsp_valid |-> req_ready ##1 !rsp_valid)
    else $error("response not a single pulse");
endmodule
bind ebt_bus_timing ebt_bus_monitor mon_u (.pclk, .presetn, .rsp_valid, .req_ready, .ale, .write_strobe_low_n,
  .write_strobe_high_n, .read_strobe_n, .bus_addr, .bus_doe);

// ---- tb/ebt_ext_mem.sv ----
// external byte memory answering the multiplexed bus
`timescale 1ns/1ps
module ebt_ext_mem (
  // clock and width
  input  wire        pclk,
  input  wire        bus16,
  // bus pins
  input  wire        write_strobe_low_n,
  input  wire        write_strobe_high_n,
  input  wire        read_strobe_n,
  input  wire [23:0] bus_addr,
  input  wire [15:0] bus_dout,
  output wire [15:0] bus_din
);
  logic [7:0]  mem [256];
  logic [15:0] last_q = 16'h0000;
  wire  [7:0]  a_odd = {bus_addr[7:1], 1'b1};
  wire  [7:0]  a_low = bus16 ? {bus_addr[7:1], 1'b0} : bus_addr[7:0];
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
  end
  always @(posedge pclk)
  begin
    if (!write_strobe_low_n) mem[a_low] <= bus_dout[7:0];
    if (!write_strobe_high_n) mem[a_odd] <= bus_dout[15:8];
    if (!read_strobe_n) last_q <= bus_din;
  end
  // released bus shows inverted data so a late sample is caught
  assign bus_din = read_strobe_n ? ~last_q : {mem[a_odd], mem[a_low]};
endmodule

// ---- tb/ebt_bus_timing_test.sv ----
// self-checking bench for the external bus timing block
`timescale 1ns/1ps
`include "ebt_defs.vh"
module ebt_bus_timing_test;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, req_valid = 0, req_write = 0;
  logic        req_word = 0, bus16 = 0, mon_on = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [23:0] req_addr = 0, ab, aw;
  logic [15:0] req_wdata = 0;
  logic [7:0]  hi = `EBT_HIGH_RST, lo = `EBT_LOW_RST;
  logic [1:0]  lanes = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, req_ready, rsp_valid, ale, bus_doe;
  wire         write_strobe_low_n, write_strobe_high_n, read_strobe_n;
  wire  [15:0] rsp_rdata, bus_dout, bus_din;
  wire  [23:0] bus_addr;
  int          mismatches = 0, samples_checked = 0, cycles = 0, ales = 0;
  int          bmem [256];
  ebt_bus_timing dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .req_valid, .req_write, .req_word, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .ale,
    .write_strobe_low_n, .write_strobe_high_n, .read_strobe_n, .bus_addr, .bus_dout, .bus_doe, .bus_din);
  ebt_ext_mem mem_u (.pclk, .bus16, .write_strobe_low_n, .write_strobe_high_n, .read_strobe_n, .bus_addr,
    .bus_dout, .bus_din);
  always #25 pclk = ~pclk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      mismatches++;
      complete_run();
    end
    if (mon_on)
    begin
      ales += ale;
      lanes |= {~write_strobe_high_n, ~write_strobe_low_n};
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (exp !== got)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    if (!wr) chk("prdata", err ? 0 : d, prdata);
    chk("pslverr", err, pslverr);
    psel <= 0;
    penable <= 0;
  endtask
  // expected length comes from the timing codes held when the request is taken
  task automatic op(input logic w, input logic wd, input logic [23:0] a, input logic [15:0] d);
    int n, m, h, exp, e;
    n = w ? hi[5:4] + 2 : hi[1:0] + 2;
    m = w ? hi[7:6] + 2 : hi[3:2] + 1;
    h = w & lo[6];
    exp = n + h + 2 + ((wd && !bus16) ? m + h + 1 : 0);
    @(posedge pclk);
    req_valid <= 1;
    req_write <= w;
    req_word <= wd;
    req_addr <= a;
    req_wdata <= d;
    @(posedge pclk);
    while (req_ready !== 1'b1) @(posedge pclk);
    req_valid <= 0;
    mon_on = 1;
    ales = 0;
    lanes = 0;
    e = 0;
    do
    begin
      @(posedge pclk);
      e++;
    end while (rsp_valid !== 1'b1 && e < 40);
    mon_on = 0;
    chk("length", exp, e);
    chk("latches", 1, ales);
    chk("lanes", !w ? 2'b00 : !bus16 ? 2'b01 : wd ? 2'b11 : a[0] ? 2'b10 : 2'b01, lanes);
    if (w)
    begin
      bmem[a[7:0]] = d[7:0];
      if (wd) bmem[a[7:0] | 8'h1] = d[15:8];
    end
    else if (wd)
      chk("word", {bmem[a[7:0] | 8'h1][7:0], bmem[a[7:0]][7:0]}, rsp_rdata);
    else
      chk("byte", bmem[a[7:0]], (bus16 && a[0]) ? rsp_rdata[15:8] : rsp_rdata[7:0]);
  endtask
  initial
  begin
    void'($urandom(36));
    foreach (bmem[i]) bmem[i] = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `EBT_OFF_HIGH, `EBT_HIGH_RST, 0);
    apb(0, `EBT_OFF_LOW, `EBT_LOW_RST, 0);
    apb(0, `EBT_OFF_CFG, `EBT_CFG_RST, 0);
    apb(1, 12'h010, 32'h5a, 1);
    apb(0, 12'h010, 0, 1);
    // idle status reads as all zero; a write to it is dropped without error
    apb(0, `EBT_OFF_STAT, 32'h0000_0000, 0);
    apb(1, `EBT_OFF_STAT, 32'h0000_00ff, 0);
    apb(0, `EBT_OFF_STAT, 32'h0000_0000, 0);
    for (int b = 0; b < 2; b++)
      for (int c = 0; c < 4; c++)
      begin
        bus16 <= b[0];
        hi = 8'h55 * c;
        lo = {c[0], c[1], 6'h00};
        apb(1, `EBT_OFF_CFG, b, 0);
        apb(1, `EBT_OFF_HIGH, hi, 0);
        apb(1, `EBT_OFF_LOW, lo, 0);
        apb(0, `EBT_OFF_HIGH, hi, 0);
        ab = $urandom;
        aw = {ab[23:1], 1'b0} ^ 24'h2;
        for (int k = 0; k < 4; k++)
          op(!k[1], k[0], k[0] ? aw : ab, $urandom);
      end
    // byte bus, so both phases of the split word write must keep the snapshot
    bus16 <= 0;
    apb(1, `EBT_OFF_CFG, 32'h0000_0000, 0);
    // timing rewritten while a slow write is under way
    fork
      op(1, 1, 24'h40, 16'hbeef);
      begin
        repeat (3) @(posedge pclk);
        apb(1, `EBT_OFF_HIGH, 0, 0);
      end
    join
    hi = 0;
    op(0, 1, 24'h40, 0);
    complete_run();
  end
endmodule
